// ---- hw/dcbr_requester.sv ----
// requester end: one link of the grant daisy chain
`include "dcbr_defines.svh"
`default_nettype none
// Behaviour
// - requester pulls request line low to ask
// - may ask when line and chain-in high
// - may ask if wanted at last rise
// - cpu releases bus, then drives acknowledge low
// - non-requester passes chain-in to chain-out
// - requester holds chain-out high, blocking lower ones
// - bus taken only after chain-in falls
// - release: stop pulling, let chain-out follow
// - line rises only after all released
// - cpu drives acknowledge high on high line
// - high acknowledge ripples, re-enabling new requests
// - echo low request until chain-out driven low
// - handshake needs no shared clock edge
// - request line open-drain with pull-up
module dcbr_requester
   import dcbr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // link
   dcbr_if.requester link,
   // user side
   input wire logic want_bus,
   input wire logic done,
   output logic bus_owned
);
   typedef struct packed {
      logic [`DCBR_SYNC_STAGES-1:0] req_sync;
      logic [`DCBR_SYNC_STAGES-1:0] chain_sync;
      logic req_prev;
      logic wanted_at_rise;
      dcbr_req_state_type state;
      logic pull;
      logic chain_out;
   } dcbr_req_regs_type;

   dcbr_req_regs_type r_q, r_d;
   // synchronised views of the two received handshake levels
   logic req_s;
   logic chain_s;
   // decoded conditions, each named after what it allows
   logic line_rose;
   logic may_ask_idle;
   logic may_ask_late;
   logic must_echo;
   logic grant_seen;
   logic ack_back;
   logic release_now;

   // state walk of one link:
   //   idle: nothing pulled, chain-out follows chain-in
   //   wait: pulling, chain-out held high, waiting for a low grant
   //   own: grant low, transactions may run
   //   done: released, waiting for the high acknowledge
   //   echo: pulling for another requester until the grant passes
   // echo keeps the line low until the low grant has passed this link,
   // so the cpu cannot see the line rise before every link has seen it;
   // the price is two extra sync delays per link on every handover

   // only the last stage is read: the first may still be metastable
   assign req_s = r_q.req_sync[`DCBR_SYNC_STAGES-1];
   assign chain_s = r_q.chain_sync[`DCBR_SYNC_STAGES-1];
   // low-to-high of the line, seen on the synchronised copy
   assign line_rose = req_s && !r_q.req_prev;
   // cpu owns the bus and nobody asks
   assign may_ask_idle = want_bus && chain_s && req_s;
   // late request: bus was wanted when the line last rose
   assign may_ask_late = want_bus && chain_s && r_q.wanted_at_rise;
   // someone else pulled the line while our grant input is high
   assign must_echo = !req_s && chain_s;
   // low grant has reached this link
   assign grant_seen = !chain_s;
   // high acknowledge has come back down the chain
   assign ack_back = chain_s;
   // user has finished its transactions
   assign release_now = done;

   always_comb begin
      r_d = r_q;
      r_d.req_sync = {r_q.req_sync[`DCBR_SYNC_STAGES-2:0], link.shared_request_line};
      r_d.chain_sync = {r_q.chain_sync[`DCBR_SYNC_STAGES-2:0], link.grant_chain_in};
      r_d.req_prev = req_s;
      // remember wanting the bus at each low-to-high of the line
      if (line_rose) begin
         r_d.wanted_at_rise = want_bus;
      end
      // chain-out follows chain-in unless this end holds it high
      r_d.chain_out = chain_s;
      unique case (r_q.state)
         DCBR_REQ_IDLE: begin
            if (may_ask_idle || may_ask_late) begin
               r_d.state = DCBR_REQ_WAIT;
               r_d.pull = 1'b1;
               r_d.chain_out = 1'b1;
               // the late-request credit is spent once
               r_d.wanted_at_rise = 1'b0;
            end else if (must_echo) begin
               r_d.state = DCBR_REQ_ECHO;
               r_d.pull = 1'b1;
            end
         end
         DCBR_REQ_ECHO: begin
            // not requesting: pass the grant on and let go on the same edge
            if (grant_seen) begin
               r_d.pull = 1'b0;
            end
            if (grant_seen && !r_q.chain_out) begin
               r_d.state = DCBR_REQ_DONE;
            end
         end
         DCBR_REQ_WAIT: begin
            r_d.chain_out = 1'b1;
            if (grant_seen) begin
               r_d.state = DCBR_REQ_OWN;
            end
         end
         DCBR_REQ_OWN: begin
            r_d.chain_out = 1'b1;
            if (release_now) begin
               r_d.state = DCBR_REQ_DONE;
               r_d.pull = 1'b0;
               // lower links may now take the grant
               r_d.chain_out = chain_s;
            end
         end
         DCBR_REQ_DONE: begin
            // no new request until the high acknowledge is back
            if (ack_back) begin
               r_d.state = DCBR_REQ_IDLE;
            end
         end
         default: begin
            r_d.state = DCBR_REQ_IDLE;
            r_d.pull = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         r_q <= '{
            req_sync: {`DCBR_SYNC_STAGES{`DCBR_LINE_IDLE}},
            chain_sync: {`DCBR_SYNC_STAGES{`DCBR_ACK_RESET}},
            req_prev: `DCBR_LINE_IDLE,
            wanted_at_rise: 1'b0,
            state: DCBR_REQ_IDLE,
            pull: 1'b0,
            chain_out: `DCBR_ACK_RESET
         };
      end else begin
         r_q <= r_d;
      end
   end

   // one stage alone would hand a metastable level to the decode
   initial begin
      if (`DCBR_SYNC_STAGES < 2) $error("need two sync stages");
      if (`DCBR_LINE_IDLE != 1'b1) $error("idle request line must be high");
      if (`DCBR_ACK_RESET != 1'b1) $error("reset acknowledge must be high");
   end

   // open-drain: drive low only, never high
   assign link.rqr_req_o = 1'b0;
   assign link.rqr_req_oe = r_q.pull;
   assign link.grant_chain_out = r_q.chain_out;
   assign bus_owned = (r_q.state == DCBR_REQ_OWN);
endmodule
`default_nettype wire

// ---- pkg/dcbr_defines.svh ----
// constants for the daisy-chain bus request handshake
`ifndef DCBR_DEFINES_SVH
`define DCBR_DEFINES_SVH
`define DCBR_SYNC_STAGES 2
`define DCBR_LINE_IDLE 1'b1
`define DCBR_ACK_RESET 1'b1
`endif

// ---- pkg/dcbr_pkg.sv ----
// types shared by both ends of the bus request handshake
`default_nettype none
package dcbr_pkg;
   typedef enum logic [1:0] {
      DCBR_CPU_OWN,
      DCBR_CPU_RELEASED
   } dcbr_cpu_state_type;

   typedef enum logic [2:0] {
      DCBR_REQ_IDLE,
      DCBR_REQ_ECHO,
      DCBR_REQ_WAIT,
      DCBR_REQ_OWN,
      DCBR_REQ_DONE
   } dcbr_req_state_type;
endpackage
`default_nettype wire

// ---- pkg/dcbr_if.sv ----
// wires between the cpu end and one requester of the chain
`default_nettype none
interface dcbr_if;
   // open-drain request line: each party gives output level and enable
   logic cpu_req_o;
   logic cpu_req_oe;
   logic rqr_req_o;
   logic rqr_req_oe;
   logic shared_request_line;
   // acknowledge into the chain, and this requester's chain links
   logic cpu_grant_ack;
   logic grant_chain_in;
   logic grant_chain_out;

   // pull-up when nobody drives low
   assign shared_request_line = !((cpu_req_oe && !cpu_req_o) || (rqr_req_oe && !rqr_req_o));

   modport cpu (
      input shared_request_line,
      output cpu_req_o,
      output cpu_req_oe,
      output cpu_grant_ack
   );
   modport requester (
      input shared_request_line,
      input grant_chain_in,
      output rqr_req_o,
      output rqr_req_oe,
      output grant_chain_out
   );
endinterface
`default_nettype wire

// ---- hw/dcbr_cpu_end.sv ----
// cpu end: releases the bus on a low request line and acknowledges
`include "dcbr_defines.svh"
`default_nettype none
module dcbr_cpu_end
   import dcbr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // link
   dcbr_if.cpu link,
   // user side
   input wire logic cpu_idle,
   output logic bus_released
);
   typedef struct packed {
      logic [`DCBR_SYNC_STAGES-1:0] req_sync;
      dcbr_cpu_state_type state;
      logic ack;
   } dcbr_cpu_regs_type;

   dcbr_cpu_regs_type r_q, r_d;

   always_comb begin
      r_d = r_q;
      // synchroniser: only the last stage is looked at
      r_d.req_sync = {r_q.req_sync[`DCBR_SYNC_STAGES-2:0], link.shared_request_line};
      unique case (r_q.state)
         DCBR_CPU_OWN: begin
            // finish own cycle before letting go
            if (!r_q.req_sync[`DCBR_SYNC_STAGES-1] && cpu_idle) begin
               r_d.state = DCBR_CPU_RELEASED;
               r_d.ack = 1'b0;
            end
         end
         DCBR_CPU_RELEASED: begin
            if (r_q.req_sync[`DCBR_SYNC_STAGES-1]) begin
               r_d.state = DCBR_CPU_OWN;
               r_d.ack = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         r_q <= '{req_sync: {`DCBR_SYNC_STAGES{`DCBR_LINE_IDLE}}, state: DCBR_CPU_OWN,
                  ack: `DCBR_ACK_RESET};
      end else begin
         r_q <= r_d;
      end
   end

   initial begin
      if (`DCBR_SYNC_STAGES < 2) $error("need two sync stages");
   end

   // cpu never pulls the request line
   assign link.cpu_req_o = 1'b0;
   assign link.cpu_req_oe = 1'b0;
   assign link.cpu_grant_ack = r_q.ack;
   assign bus_released = (r_q.state == DCBR_CPU_RELEASED);
endmodule
`default_nettype wire

// ---- bench/dcbr_monitor.sv ----
// assertions on the wires between the cpu end and one requester
`default_nettype none
module dcbr_monitor (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // link wires
   input wire logic cpu_req_oe,
   input wire logic rqr_req_oe,
   input wire logic shared_request_line,
   input wire logic cpu_grant_ack,
   input wire logic grant_chain_in,
   input wire logic grant_chain_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   sequence s_line_back;
      $rose(shared_request_line);
   endsequence
   sequence s_ack_drop;
      $fell(cpu_grant_ack);
   endsequence
   property p_ack_fall;
      s_ack_drop |-> !$past(shared_request_line, 1) && !$past(shared_request_line, 2);
   endproperty
   a_ack_fall: assert property (p_ack_fall)
      else $error("ack fell without a settled request");
   property p_ack_hold;
      !shared_request_line && !cpu_grant_ack |=> !cpu_grant_ack;
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("ack rose while request low");
   property p_ack_rise;
      s_line_back |-> ##[1:4] cpu_grant_ack;
   endproperty
   a_ack_rise: assert property (p_ack_rise)
      else $error("ack not restored");
   property p_block;
      rqr_req_oe |-> grant_chain_out;
   endproperty
   a_block: assert property (p_block)
      else $error("chain out low while pulling");
   property p_pass;
      $fell(grant_chain_out) |-> !grant_chain_in;
   endproperty
   a_pass: assert property (p_pass)
      else $error("chain out fell with chain in high");
   property p_keep_pull;
      rqr_req_oe && grant_chain_in |=> rqr_req_oe;
   endproperty
   a_keep_pull: assert property (p_keep_pull)
      else $error("pull dropped before grant");
   property p_line_rise;
      s_line_back |-> !grant_chain_out;
   endproperty
   a_line_rise: assert property (p_line_rise)
      else $error("line rose before chain released");
   property p_pullup;
      !rqr_req_oe && !cpu_req_oe |-> shared_request_line;
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("undriven line not high");
endmodule
`default_nettype wire

// ---- bench/daisy_chain_bus_request_tb.sv ----
// bench: cpu end and one requester facing each other
`default_nettype none
module daisy_chain_bus_request_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, nrst = 1'b0, cpu_idle = 1'b1, want_bus = 1'b0, done = 1'b0;
   logic bus_released, bus_owned, own_q;
   int n_fail = 0, samples_checked = 0, cyc = 0, seed = 32'h7F83, k, w;
   logic notes[$];
   dcbr_if lk();
   assign lk.grant_chain_in = lk.cpu_grant_ack;
   dcbr_cpu_end dcbr_cpu_end_i (.clock(clock), .nrst(nrst), .link(lk), .cpu_idle(cpu_idle),
      .bus_released(bus_released));
   dcbr_requester dcbr_requester_i (.clock(clock), .nrst(nrst), .link(lk),
      .want_bus(want_bus), .done(done), .bus_owned(bus_owned));
   dcbr_monitor dcbr_monitor_i (.clock(clock), .nrst(nrst), .cpu_req_oe(lk.cpu_req_oe),
      .rqr_req_oe(lk.rqr_req_oe), .shared_request_line(lk.shared_request_line),
      .cpu_grant_ack(lk.cpu_grant_ack), .grant_chain_in(lk.grant_chain_in),
      .grant_chain_out(lk.grant_chain_out));
   always #2 clock = ~clock;
   task automatic chk(input logic seen, input logic exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: saw %b expected %b", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // bounded wait, then let the edge's updates land
   task automatic wait_own(input logic v);
      for (w = 0; w < 40 && bus_owned !== v; w++) @(posedge clock);
      #1;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         end_sim();
      end
   end
   // ownership must coincide with a low grant and a released cpu
   always @(posedge clock) begin
      own_q <= bus_owned;
      if (bus_owned === 1'b1 && own_q !== 1'b1) begin
         chk(lk.grant_chain_in, notes.pop_front());
         chk(bus_released, 1'b1);
      end
   end
   initial begin
      repeat (6) @(posedge clock);
      #1 nrst = 1'b1;
      for (k = 0; k < 8; k++) begin
         cpu_idle = 1'b0;
         want_bus = 1'b1;
         notes.push_back(1'b0);
         repeat (6 + $unsigned($random(seed)) % 8) @(posedge clock);
         #1;
         chk(lk.shared_request_line, 1'b0);
         chk(lk.cpu_grant_ack, 1'b1);
         cpu_idle = 1'b1;
         wait_own(1'b1);
         repeat ($unsigned($random(seed)) % 8) @(posedge clock);
         #1 done = 1'b1;
         want_bus = 1'b0;
         @(posedge clock);
         #1 done = 1'b0;
         wait_own(1'b0);
         repeat (8) @(posedge clock);
         #1;
         chk(lk.shared_request_line, 1'b1);
         chk(lk.cpu_grant_ack, 1'b1);
         $display("transfer %0d ended", k);
      end
      want_bus = 1'b1;
      notes.push_back(1'b0);
      @(posedge clock);
      wait_own(1'b1);
      nrst = 1'b0;
      want_bus = 1'b0;
      @(posedge clock);
      #1;
      chk(lk.cpu_grant_ack, 1'b1);
      chk(bus_owned, 1'b0);
      chk(lk.rqr_req_oe, 1'b0);
      nrst = 1'b1;
      $display("reset while owning ended");
      end_sim();
   end
endmodule
`default_nettype wire
